/* File: mmd_defines.svh */
// constants for the magnet menu and status display controller
`ifndef MMD_DEFINES_SVH
`define MMD_DEFINES_SVH
`define MMD_CLK_KHZ 40000
`define MMD_DWELL_MS 3000
`define MMD_DEBOUNCE_MS 20
`define MMD_BLINK_MS 250
`define MMD_DWELL_CYCLES (`MMD_DWELL_MS * `MMD_CLK_KHZ)
`define MMD_DEBOUNCE_CYCLES (`MMD_DEBOUNCE_MS * `MMD_CLK_KHZ)
`define MMD_BLINK_CYCLES (`MMD_BLINK_MS * `MMD_CLK_KHZ)
`define MMD_ADDR_CTRL 4'h0
`define MMD_ADDR_STATE 4'h1
`define MMD_ADDR_ERR 4'h2
`define MMD_ADDR_PIDX 4'h3
`define MMD_ADDR_PDATA 4'h4
`define MMD_CTRL_RESET 8'h00
`define MMD_ERR_RX_MISS 0
`define MMD_ERR_RX_DEAD 1
`define MMD_ERR_MAIN_DEAD 2
`define MMD_ERR_RX_WARN 3
`define MMD_ERR_MAIN_WARN 4
`define MMD_ERR_KILL 5
`define MMD_ERR_W 6
`define MMD_FATAL_MASK 6'h07
`define MMD_SLOT_LAST 3'h6
`define MMD_DIGIT_MAX 4'h9
`define MMD_SYM_BLANK 5'h0a
`define MMD_SYM_DASH 5'h0b
`define MMD_SYM_B 5'h0c
`define MMD_SYM_C 5'h0d
`define MMD_SYM_D 5'h0e
`define MMD_SYM_E 5'h0f
`define MMD_SYM_F 5'h10
`define MMD_SYM_L 5'h11
`define MMD_SYM_O 5'h12
`define MMD_SYM_R 5'h13
`define MMD_SYM_S 5'h14
`endif

/* File: mmd_pkg.sv */
// types for the magnet menu and status display controller
package mmd_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_PICK = 3'h1,
    ST_ITEMS = 3'h2,
    ST_SHOW_CUR = 3'h3,
    ST_VALUE = 3'h4,
    ST_SHOW_NEW = 3'h5,
    ST_STORED = 3'h6
  } mmd_state_type;
  typedef enum logic [1:0] {
    GRP_SETUP = 2'h0,
    GRP_STATUS = 2'h1,
    GRP_DIAG = 2'h2
  } mmd_group_type;
endpackage

/* File: mmd_menu_display.sv */
// single-magnet menu controller and two-digit status display
// Behaviour
// - magnet active adds dots to display
// - three groups: setup, status, diagnostic
// - group items shown one by one, dwell each
// - confirmed item shows its present value
// - cycle value digits; confirm picks each digit
// - show new value, then stored mark
// - show stored mark, then ignition standby
// - setup menu only at power-on
// - status/diagnostic menus only with engine stopped
// - no confirmation over all items: leave menu
// - value cycle unconfirmed: keep old value
// - running: show speed and live warnings
// - stopped: show max speed or battery
// - stopped: alternate latched warnings too
// - pending warning blinks right decimal point
// - warnings clear on restart or power cycle
// - fatal fault flashes display outside menus, inhibits start
// - dead codes for receiver and main supply
// - low-warning codes for both supplies
// - receiver missing and kill-switch codes
`include "mmd_defines.svh"
module mmd_menu_display #(
  parameter int unsigned DWELL_CYCLES = `MMD_DWELL_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = `MMD_DEBOUNCE_CYCLES,
  parameter int unsigned BLINK_CYCLES = `MMD_BLINK_CYCLES,
  parameter int unsigned SETUP_ITEMS = 8,
  parameter int unsigned STATUS_ITEMS = 4,
  parameter int unsigned DIAG_ITEMS = 4
) (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic magnet_in,
  input wire logic engine_running_in,
  input wire logic [7:0] rpm_bcd_in,
  input wire logic [7:0] max_rpm_bcd_in,
  input wire logic [7:0] battery_bcd_in,
  input wire logic [`MMD_ERR_W-1:0] fault_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic [4:0] sym_left_out,
  output logic [4:0] sym_right_out,
  output logic dp_left_out,
  output logic dp_right_out,
  output logic flash_out,
  output logic start_inhibit_out,
  output logic ignition_standby_out,
  output logic store_out
);
  localparam int PARAMS = SETUP_ITEMS + STATUS_ITEMS + DIAG_ITEMS;
  localparam int DW_W = $clog2(DWELL_CYCLES);
  localparam int DB_W = $clog2(DEBOUNCE_CYCLES) + 1;
  localparam int BK_W = $clog2(BLINK_CYCLES);

  if (DWELL_CYCLES < 2 || DEBOUNCE_CYCLES < 2 || BLINK_CYCLES < 2) begin : g_chk_t
    $error("timing counts must be at least 2");
  end
  if (SETUP_ITEMS < 1 || STATUS_ITEMS < 1 || DIAG_ITEMS < 1 || PARAMS > 16) begin : g_chk_n
    $error("item counts must be 1 or more, 16 in total at most");
  end

  function automatic logic [3:0] items_of(input mmd_pkg::mmd_group_type g);
    unique case (g)
      mmd_pkg::GRP_SETUP: items_of = 4'(SETUP_ITEMS);
      mmd_pkg::GRP_STATUS: items_of = 4'(STATUS_ITEMS);
      default: items_of = 4'(DIAG_ITEMS);
    endcase
  endfunction

  function automatic logic [3:0] index_of(input mmd_pkg::mmd_group_type g,
                                          input logic [3:0] item);
    unique case (g)
      mmd_pkg::GRP_SETUP: index_of = item;
      mmd_pkg::GRP_STATUS: index_of = 4'(SETUP_ITEMS) + item;
      default: index_of = 4'(SETUP_ITEMS + STATUS_ITEMS) + item;
    endcase
  endfunction

  // next display slot: 0 is the quantity, 1..6 one per fault flag
  function automatic logic [2:0] next_slot(input logic [2:0] cur,
                                           input logic [`MMD_ERR_W-1:0] f);
    logic [2:0] s;
    s = cur;
    next_slot = 3'h0;
    for (int i = 0; i < `MMD_ERR_W; i++) begin
      s = (s == `MMD_SLOT_LAST) ? 3'h0 : s + 3'h1;
      if (next_slot == 3'h0 && s != 3'h0 && f[s - 3'h1]) next_slot = s;
      if (s == 3'h0) break;
    end
  endfunction

  mmd_pkg::mmd_state_type state, next_state;
  mmd_pkg::mmd_group_type group;
  logic mag_s1, mag_s2, mag_db, mag_db_d;
  logic [DB_W-1:0] db_cnt;
  logic [DB_W:0] boot_cnt;
  logic boot_done, setup_pending, confirm;
  logic [DW_W-1:0] dwell_cnt;
  logic tick;
  logic [BK_W-1:0] blink_cnt;
  logic blink_ph;
  logic [3:0] item, cand, pidx;
  logic tens_pos;
  logic [7:0] new_val;
  logic [7:0] params [PARAMS];
  logic [7:0] ctrl;
  logic eng_d;
  logic [`MMD_ERR_W-1:0] latched, flags;
  logic [2:0] slot;
  logic [4:0] next_l, next_r;

  // two flops before the pin reaches any logic
  always_ff @(posedge sys_clk_in) begin
    mag_s1 <= magnet_in;
    mag_s2 <= mag_s1;
  end

  // level must stay changed for the full debounce time
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      db_cnt <= '0;
      mag_db <= 1'b0;
      mag_db_d <= 1'b0;
    end else begin
      mag_db_d <= mag_db;
      if (mag_s2 == mag_db) begin
        db_cnt <= '0;
      end else if (db_cnt == DB_W'(DEBOUNCE_CYCLES - 1)) begin
        db_cnt <= '0;
        mag_db <= mag_s2;
      end else begin
        db_cnt <= db_cnt + 1'b1;
      end
    end
  end
  assign confirm = mag_db_d && !mag_db;

  // magnet seen after twice the debounce time from power-on opens setup
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      boot_cnt <= '0;
      boot_done <= 1'b0;
      setup_pending <= 1'b0;
    end else begin
      if (!boot_done) begin
        boot_cnt <= boot_cnt + 1'b1;
        if (boot_cnt == (DB_W+1)'(2 * DEBOUNCE_CYCLES)) begin
          boot_done <= 1'b1;
          setup_pending <= mag_db;
        end
      end
      if (state == mmd_pkg::ST_RUN && confirm) setup_pending <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || next_state != state || tick) dwell_cnt <= '0;
    else if (state == mmd_pkg::ST_VALUE && confirm) dwell_cnt <= '0;
    else dwell_cnt <= dwell_cnt + 1'b1;
  end
  assign tick = dwell_cnt == DW_W'(DWELL_CYCLES - 1);

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      blink_cnt <= '0;
      blink_ph <= 1'b0;
    end else if (blink_cnt == BK_W'(BLINK_CYCLES - 1)) begin
      blink_cnt <= '0;
      blink_ph <= !blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      mmd_pkg::ST_RUN:
        if (confirm && setup_pending) next_state = mmd_pkg::ST_ITEMS;
        else if (confirm && !engine_running_in) next_state = mmd_pkg::ST_PICK;
      mmd_pkg::ST_PICK:
        if (confirm) next_state = mmd_pkg::ST_ITEMS;
        else if (tick && group == mmd_pkg::GRP_DIAG) next_state = mmd_pkg::ST_RUN;
      mmd_pkg::ST_ITEMS:
        if (confirm) next_state = mmd_pkg::ST_SHOW_CUR;
        else if (tick && item == items_of(group) - 4'h1) next_state = mmd_pkg::ST_RUN;
      mmd_pkg::ST_SHOW_CUR:
        if (tick) next_state = mmd_pkg::ST_VALUE;
      mmd_pkg::ST_VALUE:
        if (confirm && !tens_pos) next_state = mmd_pkg::ST_SHOW_NEW;
        else if (!confirm && tick && cand == `MMD_DIGIT_MAX)
          next_state = mmd_pkg::ST_RUN;
      mmd_pkg::ST_SHOW_NEW:
        if (tick) next_state = mmd_pkg::ST_STORED;
      mmd_pkg::ST_STORED:
        if (tick) next_state = mmd_pkg::ST_RUN;
      default: next_state = mmd_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) state <= mmd_pkg::ST_RUN;
    else state <= next_state;
  end

  // group, item and digit bookkeeping
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      group <= mmd_pkg::GRP_STATUS;
      item <= 4'h0;
      cand <= 4'h0;
      tens_pos <= 1'b1;
      new_val <= 8'h00;
    end else begin
      unique case (state)
        mmd_pkg::ST_RUN: begin
          group <= setup_pending ? mmd_pkg::GRP_SETUP : mmd_pkg::GRP_STATUS;
          item <= 4'h0;
        end
        mmd_pkg::ST_PICK:
          if (tick && !confirm) group <= mmd_pkg::GRP_DIAG;
        mmd_pkg::ST_ITEMS:
          if (tick && !confirm) item <= item + 4'h1;
        mmd_pkg::ST_SHOW_CUR: begin
          cand <= 4'h0;
          tens_pos <= 1'b1;
          new_val <= params[index_of(group, item)];
        end
        mmd_pkg::ST_VALUE:
          if (confirm) begin
            if (tens_pos) new_val[7:4] <= cand;
            else new_val[3:0] <= cand;
            tens_pos <= 1'b0;
            cand <= 4'h0;
          end else if (tick) begin
            cand <= cand + 4'h1;
          end
        default: begin
        end
      endcase
    end
  end

  // a value is written only when the stored mark is reached
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      for (int i = 0; i < PARAMS; i++) params[i] <= 8'h00;
      store_out <= 1'b0;
    end else begin
      store_out <= 1'b0;
      if (state == mmd_pkg::ST_SHOW_NEW && tick) begin
        params[index_of(group, item)] <= new_val;
        store_out <= 1'b1;
      end
    end
  end

  // set wins over the clear on a restart in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      eng_d <= 1'b0;
      latched <= '0;
    end else begin
      eng_d <= engine_running_in;
      if (engine_running_in && !eng_d) latched <= fault_in;
      else latched <= latched | fault_in;
    end
  end
  assign flags = engine_running_in ? fault_in : latched;

  always_ff @(posedge sys_clk_in) begin
    if (srst_in || state != mmd_pkg::ST_RUN) slot <= 3'h0;
    else if (tick) slot <= next_slot(slot, flags);
  end

  always_comb begin
    next_l = `MMD_SYM_BLANK;
    next_r = `MMD_SYM_BLANK;
    unique case (state)
      mmd_pkg::ST_RUN:
        unique case (slot)
          3'h1: begin next_l = `MMD_SYM_R; next_r = `MMD_SYM_E; end
          3'h2: begin next_l = `MMD_SYM_R; next_r = `MMD_SYM_D; end
          3'h3: begin next_l = `MMD_SYM_B; next_r = `MMD_SYM_D; end
          3'h4: begin next_l = `MMD_SYM_R; next_r = `MMD_SYM_L; end
          3'h5: begin next_l = `MMD_SYM_B; next_r = `MMD_SYM_L; end
          3'h6: begin next_l = `MMD_SYM_O; next_r = `MMD_SYM_F; end
          default:
            if (engine_running_in) begin
              next_l = {1'b0, rpm_bcd_in[7:4]};
              next_r = {1'b0, rpm_bcd_in[3:0]};
            end else if (ctrl[0]) begin
              next_l = {1'b0, battery_bcd_in[7:4]};
              next_r = {1'b0, battery_bcd_in[3:0]};
            end else begin
              next_l = {1'b0, max_rpm_bcd_in[7:4]};
              next_r = {1'b0, max_rpm_bcd_in[3:0]};
            end
        endcase
      mmd_pkg::ST_PICK, mmd_pkg::ST_ITEMS: begin
        unique case (group)
          mmd_pkg::GRP_SETUP: next_l = `MMD_SYM_C;
          mmd_pkg::GRP_STATUS: next_l = `MMD_SYM_S;
          default: next_l = `MMD_SYM_D;
        endcase
        next_r = (state == mmd_pkg::ST_PICK) ? `MMD_SYM_DASH : {1'b0, item};
      end
      mmd_pkg::ST_SHOW_CUR, mmd_pkg::ST_SHOW_NEW: begin
        next_l = {1'b0, (state == mmd_pkg::ST_SHOW_CUR) ?
                  params[index_of(group, item)][7:4] : new_val[7:4]};
        next_r = {1'b0, (state == mmd_pkg::ST_SHOW_CUR) ?
                  params[index_of(group, item)][3:0] : new_val[3:0]};
      end
      mmd_pkg::ST_VALUE: begin
        next_l = {1'b0, tens_pos ? cand : new_val[7:4]};
        next_r = tens_pos ? `MMD_SYM_DASH : {1'b0, cand};
      end
      default: begin
        next_l = `MMD_SYM_DASH;
        next_r = `MMD_SYM_DASH;
      end
    endcase
  end

  // display flops; the dots track the debounced magnet, not the raw pin
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sym_left_out <= `MMD_SYM_BLANK;
      sym_right_out <= `MMD_SYM_BLANK;
      dp_left_out <= 1'b0;
      dp_right_out <= 1'b0;
      flash_out <= 1'b0;
      start_inhibit_out <= 1'b0;
      ignition_standby_out <= 1'b0;
    end else begin
      sym_left_out <= next_l;
      sym_right_out <= next_r;
      dp_left_out <= mag_db;
      dp_right_out <= mag_db || ((|flags) && blink_ph);
      flash_out <= (|(fault_in & `MMD_FATAL_MASK)) && state == mmd_pkg::ST_RUN;
      start_inhibit_out <= |(fault_in & `MMD_FATAL_MASK);
      ignition_standby_out <= next_state == mmd_pkg::ST_RUN &&
                              !(|(fault_in & `MMD_FATAL_MASK));
    end
  end

  // register port: read data stands the cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ctrl <= `MMD_CTRL_RESET;
      pidx <= 4'h0;
      rdata_out <= 8'h00;
    end else begin
      if (wr_in && addr_in == `MMD_ADDR_CTRL) ctrl <= wdata_in;
      if (wr_in && addr_in == `MMD_ADDR_PIDX) pidx <= wdata_in[3:0];
      rdata_out <= 8'h00;
      if (rd_in) begin
        unique case (addr_in)
          `MMD_ADDR_CTRL: rdata_out <= ctrl;
          `MMD_ADDR_STATE: rdata_out <= {2'h0, setup_pending, group, state};
          `MMD_ADDR_ERR: rdata_out <= {2'h0, latched};
          `MMD_ADDR_PIDX: rdata_out <= {4'h0, pidx};
          `MMD_ADDR_PDATA: rdata_out <= (32'(pidx) < PARAMS) ? params[pidx] : 8'h00;
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  a_confirm_once: assert property (confirm |=> !confirm [*2])
    else $error("confirm lasted more than one cycle");
  a_run_locked: assert property (state == mmd_pkg::ST_RUN && engine_running_in
    && !setup_pending && confirm |=> state == mmd_pkg::ST_RUN)
    else $error("menu entered while engine runs");
  a_setup_boot: assert property ($rose(setup_pending) |-> $rose(boot_done))
    else $error("setup opened outside power-on");
  a_items_expire: assert property (state == mmd_pkg::ST_ITEMS && tick && !confirm
    && item == items_of(group) - 4'h1 |=> state == mmd_pkg::ST_RUN)
    else $error("menu did not expire");
  a_value_kept: assert property (state == mmd_pkg::ST_VALUE && tick && !confirm
    && cand == `MMD_DIGIT_MAX |=> state == mmd_pkg::ST_RUN ##1 !store_out [*2])
    else $error("unconfirmed value stored");
  a_store_run: assert property (store_out |-> $past(state) == mmd_pkg::ST_SHOW_NEW
    && state == mmd_pkg::ST_STORED)
    else $error("store without new value shown");
  a_ack_dots: assert property ($rose(mag_db) |=> dp_left_out && dp_right_out)
    else $error("magnet not acknowledged");
  a_fault_inhibit: assert property (|(fault_in & `MMD_FATAL_MASK)
    |=> start_inhibit_out)
    else $error("fatal fault did not inhibit start");
  a_latch_hold: assert property (latched[`MMD_ERR_KILL]
    && !(engine_running_in && !eng_d) |=> latched[`MMD_ERR_KILL])
    else $error("warning cleared without restart");
  a_dp_blink: assert property (!mag_db && (|flags) && blink_ph |=> dp_right_out)
    else $error("pending warning not blinking");

  c_setup_entry: cover property (state == mmd_pkg::ST_RUN ##1 state == mmd_pkg::ST_ITEMS
    && group == mmd_pkg::GRP_SETUP);
  c_value_stored: cover property (store_out);
  c_error_slot: cover property (state == mmd_pkg::ST_RUN && slot != 3'h0);
endmodule

/* File: mmd_user_model.sv */
// user-side model: programming magnet held over power-up or swept past the sensor
module mmd_user_model #(
  parameter int unsigned HOLD_CYCLES = 9
) (
  input wire logic sys_clk_in,
  input wire logic boot_hold_in,
  input wire logic go_in,
  output logic magnet_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  initial begin
    cnt = 0;
    busy_out = 1'b0;
  end
  // hold past the debounce span, then remove: one sweep, one selection
  always @(posedge sys_clk_in) begin
    if (go_in && !busy_out) begin
      busy_out <= 1'b1;
      cnt <= HOLD_CYCLES;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end else begin
      busy_out <= 1'b0;
    end
  end
  // magnet kept at the housing across power-up, removed afterwards
  assign magnet_out = boot_hold_in | (busy_out & (cnt != 0));
endmodule

/* File: magnet_menu_and_status_display_tb_top.sv */
// self-checking bench for the magnet menu and status display controller
module magnet_menu_and_status_display_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, mag, run, wr, rd, boot, go, busy;
  logic dpl, dpr, flash, inh, stby, store;
  logic [7:0] rpm, maxr, bat, wdata, rdata, d;
  logic [5:0] fault;
  logic [3:0] addr;
  logic [4:0] sl, sr;
  int fails, total_checks, n_store, h;
  mmd_menu_display #(.DWELL_CYCLES(20), .DEBOUNCE_CYCLES(4), .BLINK_CYCLES(3)) u_mmd_menu_display (
    .sys_clk_in(clk), .srst_in(srst), .magnet_in(mag), .engine_running_in(run),
    .rpm_bcd_in(rpm), .max_rpm_bcd_in(maxr), .battery_bcd_in(bat), .fault_in(fault),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .sym_left_out(sl), .sym_right_out(sr), .dp_left_out(dpl), .dp_right_out(dpr),
    .flash_out(flash), .start_inhibit_out(inh), .ignition_standby_out(stby), .store_out(store));
  mmd_user_model u_mmd_user_model (.sys_clk_in(clk), .boot_hold_in(boot), .go_in(go),
    .magnet_out(mag), .busy_out(busy));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // store pulses counted per cycle, so a stretched pulse shows as extra stores
  always @(posedge clk) begin
    if (store === 1'b1) n_store++;
  end
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic wait_state(input logic [2:0] s, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd_reg(4'h1, d);
      if (d[2:0] === s) break;
    end
    check({13'h0, d[2:0]}, {13'h0, s});
  endtask
  task automatic wait_disp(input logic [4:0] l, input logic [4:0] r);
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (sl === l && sr === r) break;
    end
    check({6'h0, sl, sr}, {6'h0, l, r});
  endtask
  task automatic wait_sym(input logic [4:0] v);
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (sl === v || sr === v) break;
    end
    check({15'h0, sl === v || sr === v}, 16'h1);
  endtask
  // dot must still be lit as the magnet leaves, before debounce drops it
  task automatic press;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    check({15'h0, dpl}, 16'h1);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
  initial begin
    srst = 1'b1;
    run = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    boot = 1'b0;
    go = 1'b0;
    rpm = 8'h45;
    maxr = 8'h87;
    bat = 8'h72;
    fault = 6'h00;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (6) @(posedge clk);
    check({6'h0, sl, sr}, 16'h014a);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    check({15'h0, stby}, 16'h1);
    // register port: read-back, one-cycle data, unmapped and read-only places
    wr_reg(4'h0, 8'h01);
    rd_reg(4'h0, d);
    check({8'h0, d}, 16'h1);
    @(negedge clk);
    check({8'h0, rdata}, 16'h0);
    rd_reg(4'h5, d);
    check({8'h0, d}, 16'h0);
    wr_reg(4'h1, 8'hff);
    rd_reg(4'h1, d);
    check({8'h0, d}, 16'h0008);
    wait_disp(5'h07, 5'h02);
    wr_reg(4'h0, 8'h00);
    wait_disp(5'h08, 5'h07);
    // running: speed shown, magnet ignored
    @(posedge clk);
    run <= 1'b1;
    wait_disp(5'h04, 5'h05);
    press;
    repeat (12) @(posedge clk);
    wait_state(3'h0, 1);
    @(posedge clk);
    fault <= 6'h08;
    wait_disp(5'h13, 5'h11);
    rd_reg(4'h2, d);
    check({8'h0, d}, 16'h0008);
    @(posedge clk);
    fault <= 6'h10;
    wait_disp(5'h0c, 5'h11);
    h = 0;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (dpr === 1'b1) h++;
    end
    check({15'h0, h > 0 && h < 40}, 16'h1);
    @(posedge clk);
    fault <= 6'h05;
    repeat (3) @(negedge clk);
    check({13'h0, inh, stby, flash}, 16'h5);
    wait_disp(5'h13, 5'h0f);
    wait_disp(5'h0c, 5'h0e);
    @(posedge clk);
    fault <= 6'h22;
    wait_disp(5'h13, 5'h0e);
    wait_disp(5'h12, 5'h10);
    // stopped: latched faults kept and shown in turn, cleared by a restart
    @(posedge clk);
    fault <= 6'h00;
    run <= 1'b0;
    rd_reg(4'h2, d);
    check({8'h0, d}, 16'h003f);
    wait_disp(5'h12, 5'h10);
    @(posedge clk);
    run <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(4'h2, d);
    check({8'h0, d}, 16'h0000);
    check({14'h0, inh, stby}, 16'h1);
    // stopped menu, value never confirmed: nothing stored
    @(posedge clk);
    run <= 1'b0;
    repeat (3) @(posedge clk);
    press;
    wait_state(3'h1, 20);
    press;
    wait_state(3'h2, 40);
    check({15'h0, d[4:3] != 2'h0}, 16'h1);
    press;
    wait_state(3'h4, 60);
    h = n_store;
    wait_state(3'h0, 200);
    check(16'(n_store - h), 16'h0);
    wr_reg(4'h3, 8'h08);
    rd_reg(4'h4, d);
    check({8'h0, d}, 16'h0);
    // stopped menu, items run out unconfirmed
    press;
    wait_state(3'h1, 20);
    press;
    wait_state(3'h2, 40);
    wait_state(3'h0, 100);
    check({15'h0, stby}, 16'h1);
    // setup menu only via magnet held through power-up
    @(posedge clk);
    boot <= 1'b1;
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (15) @(posedge clk);
    boot <= 1'b0;
    wait_state(3'h2, 40);
    check({14'h0, d[4:3]}, 16'h0);
    wait_disp(5'h0d, 5'h01);
    press;
    wait_state(3'h4, 60);
    wait_sym(5'h03);
    press;
    wait_sym(5'h05);
    h = n_store;
    press;
    wait_disp(5'h03, 5'h05);
    wait_disp(5'h0b, 5'h0b);
    check(16'(n_store - h), 16'h1);
    wait_state(3'h0, 40);
    check({15'h0, stby}, 16'h1);
    wr_reg(4'h3, 8'h01);
    rd_reg(4'h4, d);
    check({8'h0, d}, 16'h0035);
    tally_and_finish;
  end
endmodule
